// ===== hw/standby_reset_control.sv
`timescale 1ns/100ps
// Overview of operation
// - Pending unmasked interrupt turns STOP into HALT
// - Crystal wait counts only with oscillation present
// - STOP leaves low-speed oscillator state unchanged
// - Amplifier option withholds CPU clock after release
// - Reset stops oscillators, ignores external clocks
// - Reset holds STOP; ports float, one drives low
// - Detector reset leaves detector itself running
// - Watchdog overflow reset also resets watchdog
// - Power-on clear zeroes the cause flags
module standby_reset_control #(
  parameter int unsigned NIRQ      = 8,
  parameter int unsigned PRESC     = standby_reset_pkg::PRESC_DEF,
  parameter int unsigned STAB_BASE = standby_reset_pkg::STAB_BASE_DEF,
  parameter int unsigned CW        = 16
) (
  input  wire logic                              i_clk_sys,
  input  wire logic                              i_reset,
  input  wire logic [standby_reset_pkg::AW-1:0]  i_addr,
  input  wire logic [standby_reset_pkg::DW-1:0]  i_wdata,
  input  wire logic                              i_wr,
  input  wire logic                              i_rd,
  output logic      [standby_reset_pkg::DW-1:0]  o_rdata,
  input  wire logic                              i_stop_req,
  input  wire logic [NIRQ-1:0]                   i_int_flag,
  input  wire logic [NIRQ-1:0]                   i_int_mask,
  input  wire logic                              i_main_osc_present,
  input  wire logic                              i_cpu_clk_ihs,
  input  wire logic                              i_ext_clk_tick,
  input  wire logic                              i_reset_pin_n,
  input  wire logic                              i_wdt_overflow,
  input  wire logic                              i_lvd_detect,
  input  wire logic                              i_poc_detect,
  input  wire logic                              i_reset_low_port_pin_i,
  output logic                                   o_reset_low_port_pin_o,
  output logic                                   o_reset_low_port_pin_oe_n,
  output logic                                   o_port_hiz,
  output logic                                   o_cpu_clk_en,
  output logic                                   o_halt,
  output logic                                   o_stop,
  output logic                                   o_main_crystal_osc_en,
  output logic                                   o_sub_crystal_osc_en,
  output logic                                   o_ihs_osc_en,
  output logic                                   o_ils_osc_en,
  output logic                                   o_ext_main_clk_valid,
  output logic                                   o_ext_sub_clk_valid,
  output logic                                   o_rst_core,
  output logic                                   o_rst_wdt,
  output logic                                   o_rst_lvd,
  output logic                                   o_irq
);

  // Prescaler width
  localparam int unsigned PW = (PRESC > 1) ? $clog2(PRESC) : 1;
  // Wide enough for the longer of the two hold-off loads
  // Hold counter width
  localparam int unsigned HW = 10;
  // Prescaler reload
  localparam logic [PW-1:0] PRESC_LD = PW'(PRESC - 1);
  // Hold reload, internal oscillator case
  localparam logic [HW-1:0] HOLD_IHS_LD = HW'(standby_reset_pkg::HOLD_IHS_CYC - 1);
  // Hold reload, external clock case
  localparam logic [HW-1:0] HOLD_EXT_LD = HW'(standby_reset_pkg::HOLD_EXT_CLKS - 1);

  // Whole state of the sequencer
  typedef struct packed {
    standby_reset_pkg::mode_e mode;      // Standby sequencer state
    logic [PW-1:0]            presc;     // Wait tick divider
    logic [HW-1:0]            hold;      // CPU clock hold-off count
    logic [2:0]               sel;       // stab_time_select
    logic                     high_speed_amp_option;      // high_speed_amp_option
    logic                     ils_off;   // Software stop of low-speed osc
    logic                     high_speed_amp_option_lat;  // Option seen at STOP entry
    logic                     ihs_lat;   // CPU on internal osc at entry
    logic                     pin_low;   // Reset pin level, delayed
    logic [1:0]               cause;     // reset_cause_flags
    logic [3:0]               ists;      // Sticky event flags
    logic [3:0]               imask;     // Event enables
    logic [7:0]               rdata;     // Read data
    logic                     rst_core;  // Reset to rest of device
    logic                     rst_wdt;   // Reset to watchdog
    logic                     rst_lvd;   // Reset to voltage detector
  } seq_s;

  seq_s q;
  seq_s d;

  // Timer link
  stab_if #(.CW(CW)) stab ();

  // Stabilisation wait counter
  stab_timer #(
    .CW (CW)
  ) u_stab (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .bus       (stab)
  );

  // Combinational helpers of the sequencer
  logic          tick;      // Divided wait tick
  logic          pending;   // Unmasked interrupt present
  logic          pin_low;   // Reset pin asserted
  logic          start;     // Restart wait counter
  logic [2:0]    sel_cap;   // Clipped selection
  logic [3:0]    ev;        // Events this cycle
  logic [3:0]    w1c;       // Clear mask from software

  // One-cycle tick keeps the whole block on a single clock
  // Divider and source decode
  assign tick    = (q.presc == '0);
  assign pending = |(i_int_flag & ~i_int_mask);
  assign pin_low = ~i_reset_pin_n;
  assign sel_cap = (q.sel > standby_reset_pkg::SEL_MAX) ? standby_reset_pkg::SEL_MAX : q.sel;

  // Selections above the top step are clipped to it
  // Wait length from selection
  assign stab.limit   = CW'(STAB_BASE) << sel_cap;
  assign stab.start   = start;
  assign stab.tick_en = tick && i_main_osc_present;

  // Sequencer, registers and reset routing
  always_comb begin
    d       = q;
    start   = 1'b0;
    ev      = '0;
    w1c     = '0;
    d.presc = tick ? PRESC_LD : q.presc - PW'(1);
    d.pin_low = pin_low;

    unique case (q.mode)
      standby_reset_pkg::MODE_RUN: begin
        if (i_stop_req) begin
          // Capture clock setup at entry
          d.high_speed_amp_option_lat = q.high_speed_amp_option;
          d.ihs_lat  = i_cpu_clk_ihs;
          start      = 1'b1;
          if (pending) begin
            d.mode = standby_reset_pkg::MODE_HALT;
            ev[standby_reset_pkg::IRQ_HALT] = 1'b1;
          end else begin
            // Nothing pending, main crystal and internal high-speed oscillators stop
            d.mode = standby_reset_pkg::MODE_STOP;
          end
        end
      end
      standby_reset_pkg::MODE_STOP: begin
        // Interrupt releases STOP
        if (pending) begin
          start  = 1'b1;
          d.hold = q.ihs_lat ? HOLD_IHS_LD : HOLD_EXT_LD;
          ev[standby_reset_pkg::IRQ_REL] = 1'b1;
          if (!q.ihs_lat) begin
            // Crystal CPU waits for oscillation
            d.mode = standby_reset_pkg::MODE_WOSC;
          end else if (q.high_speed_amp_option_lat) begin
            // Internal osc CPU, hold-off only
            d.mode = standby_reset_pkg::MODE_HOLD;
          end else begin
            // No hold-off, clock back at once
            d.mode = standby_reset_pkg::MODE_RUN;
          end
        end
      end
      standby_reset_pkg::MODE_WOSC: begin
        if (i_main_osc_present) begin
          // Oscillation seen, counting may begin
          d.mode = standby_reset_pkg::MODE_STAB;
        end
      end
      standby_reset_pkg::MODE_STAB: begin
        // Wait for selected time
        if (stab.done) begin
          ev[standby_reset_pkg::IRQ_STAB] = 1'b1;
          d.mode = q.high_speed_amp_option_lat ? standby_reset_pkg::MODE_HOLD
                              : standby_reset_pkg::MODE_RUN;
        end
      end
      standby_reset_pkg::MODE_HOLD: begin
        if (q.ihs_lat || i_ext_clk_tick) begin
          if (q.hold == '0) begin
            d.mode = standby_reset_pkg::MODE_RUN;
          end else begin
            // One step per CPU clock edge
            d.hold = q.hold - HW'(1);
          end
        end
      end
      standby_reset_pkg::MODE_HALT: begin
        // Clocks keep running, only the CPU waits
        // Resume after wait
        if (stab.done) begin
          ev[standby_reset_pkg::IRQ_STAB] = 1'b1;
          d.mode = standby_reset_pkg::MODE_RUN;
        end
      end
      default: begin
        // Illegal code recovers to run
        d.mode = standby_reset_pkg::MODE_RUN;
      end
    endcase

    // Applied last so no branch above escapes the freeze
    // Hold state while pin low
    if (pin_low) begin
      d.mode = q.mode;
      d.hold = q.hold;
      start  = 1'b0;
    end else if (q.pin_low) begin
      // Pin released, restart in run
      d.mode = standby_reset_pkg::MODE_RUN;
    end

    // Reset outputs are registered, one cycle behind their source
    // Watchdog resets itself
    d.rst_wdt  = pin_low | i_wdt_overflow | i_lvd_detect | i_poc_detect;
    d.rst_lvd  = pin_low | i_wdt_overflow | i_poc_detect;
    d.rst_core = pin_low | i_wdt_overflow | i_lvd_detect | i_poc_detect;
    if (i_wdt_overflow || i_lvd_detect) begin
      ev[standby_reset_pkg::IRQ_RST] = 1'b1;
    end

    // Register writes
    if (i_wr) begin
      unique case (i_addr)
        standby_reset_pkg::OFS_CTRL: begin
          d.sel     = i_wdata[standby_reset_pkg::CTRL_SEL_LSB +: 3];
          d.high_speed_amp_option    = i_wdata[standby_reset_pkg::CTRL_HIGH_SPEED_AMP_OPTION];
          d.ils_off = i_wdata[standby_reset_pkg::CTRL_ILS_OFF];
        end
        standby_reset_pkg::OFS_ISTS: begin
          // Write one to clear
          w1c = i_wdata[3:0];
        end
        standby_reset_pkg::OFS_IMASK: begin
          d.imask = i_wdata[3:0];
        end
        default: begin
          // Read-only or unmapped
        end
      endcase
    end

    // Sticky flags, set wins
    d.ists = (q.ists & ~w1c) | ev;

    // Cause flags clear on read, set wins
    if (i_rd && (i_addr == standby_reset_pkg::OFS_CAUSE)) begin
      d.cause = '0;
    end
    if (i_lvd_detect) begin
      d.cause[standby_reset_pkg::CAUSE_LVD] = 1'b1;
    end
    if (i_wdt_overflow) begin
      d.cause[standby_reset_pkg::CAUSE_WDT] = 1'b1;
    end
    // Placed last so it beats both a set and a read clear
    // Power-on clear zeroes
    if (i_poc_detect) begin
      d.cause = '0;
    end

    // Register reads, unmapped gives zero
    d.rdata = '0;
    if (i_rd) begin
      unique case (i_addr)
        standby_reset_pkg::OFS_CTRL: begin
          d.rdata = {3'h0, q.ils_off, q.high_speed_amp_option, q.sel};
        end
        standby_reset_pkg::OFS_STAB: begin
          // stab_time_status_counter view
          // Upper byte of the running count
          d.rdata = stab.count[CW-1 -: 8];
        end
        standby_reset_pkg::OFS_CAUSE: begin
          d.rdata = {6'h0, q.cause};
        end
        standby_reset_pkg::OFS_ISTS: begin
          d.rdata = {4'h0, q.ists};
        end
        standby_reset_pkg::OFS_IMASK: begin
          d.rdata = {4'h0, q.imask};
        end
        standby_reset_pkg::OFS_STATE: begin
          d.rdata = {i_reset_low_port_pin_i, 3'h0, stab.done, q.mode};
        end
        default: begin
          d.rdata = '0;
        end
      endcase
    end
  end

  // Async reset puts the sequencer in run with all flags clear
  // State register
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Read data and reset outputs
  assign o_rdata    = q.rdata;
  assign o_rst_core = q.rst_core;
  assign o_rst_wdt  = q.rst_wdt;
  assign o_rst_lvd  = q.rst_lvd;
  assign o_irq      = |(q.ists & q.imask);

  // Mode indications
  assign o_stop       = (q.mode == standby_reset_pkg::MODE_STOP);
  assign o_halt       = (q.mode == standby_reset_pkg::MODE_HALT);
  assign o_cpu_clk_en = (q.mode == standby_reset_pkg::MODE_RUN) && !pin_low;

  // Pin-driven enables are combinational to act in the same cycle
  // Oscillators off in reset
  assign o_main_crystal_osc_en = !pin_low && !o_stop;
  assign o_ihs_osc_en          = !pin_low && !o_stop;
  assign o_sub_crystal_osc_en  = !pin_low;
  assign o_ext_main_clk_valid  = !pin_low && !o_stop;
  assign o_ext_sub_clk_valid   = !pin_low;
  assign o_ils_osc_en          = !pin_low && !q.ils_off;

  // The one pin drives low through an active-low enable
  // Ports float, one drives low
  assign o_port_hiz                = pin_low;
  assign o_reset_low_port_pin_o    = 1'b0;
  assign o_reset_low_port_pin_oe_n = !pin_low;

endmodule

// ===== hw/standby_reset_pkg.sv
package standby_reset_pkg;

  // Register port widths
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 8;

  // Register offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STAB   = 8'h04;
  localparam logic [7:0] OFS_CAUSE  = 8'h08;
  localparam logic [7:0] OFS_ISTS   = 8'h0c;
  localparam logic [7:0] OFS_IMASK  = 8'h10;
  localparam logic [7:0] OFS_STATE  = 8'h14;

  // Control register fields
  localparam int unsigned CTRL_SEL_LSB = 0;
  localparam int unsigned CTRL_HIGH_SPEED_AMP_OPTION    = 3;
  localparam int unsigned CTRL_ILS_OFF = 4;
  localparam logic [2:0]  SEL_MAX      = 3'h4;

  // Reset cause fields
  localparam int unsigned CAUSE_LVD = 0;
  localparam int unsigned CAUSE_WDT = 1;

  // Interrupt status fields
  localparam int unsigned IRQ_REL   = 0;
  localparam int unsigned IRQ_HALT  = 1;
  localparam int unsigned IRQ_STAB  = 2;
  localparam int unsigned IRQ_RST   = 3;
  localparam int unsigned IRQ_N     = 4;

  // Timing
  localparam int unsigned CLK_MHZ       = 200;
  localparam real         HOLD_MIN_US   = 4.06;
  localparam real         HOLD_MAX_US   = 16.12;
  localparam int unsigned HOLD_IHS_CYC  = int'($ceil(HOLD_MIN_US * CLK_MHZ));
  localparam int unsigned HOLD_EXT_CLKS = 160;
  localparam int unsigned PRESC_DEF     = 16;
  localparam int unsigned STAB_BASE_DEF = 64;

  // Standby sequencer states, Gray along the stop path
  typedef enum logic [2:0] {
    MODE_RUN  = 3'h0,
    MODE_STOP = 3'h1,
    MODE_WOSC = 3'h3,
    MODE_STAB = 3'h2,
    MODE_HOLD = 3'h6,
    MODE_HALT = 3'h4
  } mode_e;

endpackage

// ===== hw/stab_if.sv
`timescale 1ns/100ps
// Link between sequencer and stabilisation timer
interface stab_if #(
  parameter int unsigned CW = 16
);
  logic          start;   // Clear count, one cycle
  logic          tick_en; // Count one step
  logic [CW-1:0] limit;   // Selected wait length
  logic [CW-1:0] count;   // Elapsed wait
  logic          done;    // Count reached limit

  modport ctrl  (output start, tick_en, limit, input count, done);
  modport timer (input start, tick_en, limit, output count, done);
endinterface

// ===== hw/stab_timer.sv
`timescale 1ns/100ps
// Saturating stabilisation wait counter
module stab_timer #(
  parameter int unsigned CW = 16
) (
  input  wire logic i_clk_sys,
  input  wire logic i_reset,
  stab_if.timer     bus
);

  // Whole state of the timer
  typedef struct packed {
    logic [CW-1:0] count; // Elapsed ticks
  } tmr_s;

  tmr_s q;
  tmr_s d;

  // Done once the limit is met
  assign bus.done  = (q.count >= bus.limit);
  assign bus.count = q.count;

  // Next count
  always_comb begin
    d = q;
    if (bus.start) begin
      // Restart from zero
      d.count = '0;
    end else if (bus.tick_en && !bus.done) begin
      // Step, stops at limit
      d.count = q.count + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // State register
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule

// ===== bench/standby_reset_chk.sv
`timescale 1ns/100ps
// Port-level checks of standby entry, reset outputs and oscillators
module standby_reset_chk #(
  parameter int unsigned NIRQ = 8
) (
  input wire logic            i_clk_sys,
  input wire logic            i_reset,
  input wire logic            i_stop_req,
  input wire logic [NIRQ-1:0] i_int_flag,
  input wire logic [NIRQ-1:0] i_int_mask,
  input wire logic            i_reset_pin_n,
  input wire logic            i_wdt_overflow,
  input wire logic            i_lvd_detect,
  input wire logic            i_poc_detect,
  input wire logic            o_reset_low_port_pin_o,
  input wire logic            o_reset_low_port_pin_oe_n,
  input wire logic            o_port_hiz,
  input wire logic            o_cpu_clk_en,
  input wire logic            o_halt,
  input wire logic            o_stop,
  input wire logic            o_main_crystal_osc_en,
  input wire logic            o_sub_crystal_osc_en,
  input wire logic            o_ihs_osc_en,
  input wire logic            o_ils_osc_en,
  input wire logic            o_ext_main_clk_valid,
  input wire logic            o_ext_sub_clk_valid,
  input wire logic            o_rst_core,
  input wire logic            o_rst_wdt,
  input wire logic            o_rst_lvd
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  // Any unmasked request pending
  wire pend = |(i_int_flag & ~i_int_mask);
  // Any oscillator or external clock still enabled
  wire any_osc = o_main_crystal_osc_en | o_sub_crystal_osc_en | o_ihs_osc_en |
                 o_ils_osc_en | o_ext_main_clk_valid | o_ext_sub_clk_valid;

  chk_halt_fallback: assert property (i_stop_req && o_cpu_clk_en && pend |=> o_halt && !o_stop)
    else $error("stop with pending request did not fall back to halt");
  chk_stop_entry: assert property (i_stop_req && o_cpu_clk_en && !pend |=> o_stop && !o_halt)
    else $error("stop without pending request not entered");
  chk_ils_kept: assert property ($rose(o_stop) && i_reset_pin_n |-> $stable(o_ils_osc_en))
    else $error("low-speed oscillator changed on stop entry");
  chk_osc_off: assert property (!i_reset_pin_n |-> !any_osc)
    else $error("clock source enabled during reset pin");
  chk_port_float: assert property (!i_reset_pin_n |-> o_port_hiz && !o_reset_low_port_pin_oe_n && !o_reset_low_port_pin_o)
    else $error("ports not floated with one pin low");
  chk_stop_frozen: assert property (o_stop && !i_reset_pin_n |=> o_stop)
    else $error("stop state lost during reset pin");
  chk_lvd_spared: assert property (i_lvd_detect && !i_wdt_overflow && !i_poc_detect && i_reset_pin_n |=> o_rst_core && !o_rst_lvd)
    else $error("detector reset wrongly applied");
  chk_wdt_self: assert property (i_wdt_overflow |=> o_rst_wdt && o_rst_core)
    else $error("watchdog reset missing");

  cover property (i_stop_req && pend);
  cover property ($fell(o_stop) && i_reset_pin_n);
  cover property (o_stop && !i_reset_pin_n);
  cover property ($rose(o_rst_wdt));
endmodule

bind standby_reset_control standby_reset_chk #(.NIRQ(NIRQ)) u_chk (.*);

// ===== bench/standby_far_side.sv
`timescale 1ns/100ps
// Main crystal with start-up delay, and a free external clock
module standby_far_side #(
  parameter int unsigned START_CYC = 40, // Crystal start-up cycles
  parameter int unsigned EXT_DIV   = 3   // System cycles per external clock
) (
  input  wire logic i_clk_sys,
  input  wire logic i_osc_en,
  input  wire logic i_ext_valid,
  output logic      o_osc_present,
  output logic      o_ext_tick
);
  int unsigned run_q = 0; // Cycles since crystal enabled
  int unsigned div_q = 0; // External clock divider
  // Start-up and divider counters
  always_ff @(posedge i_clk_sys) begin
    run_q <= i_osc_en ? ((run_q < START_CYC) ? run_q + 1 : run_q) : 0;
    div_q <= (div_q >= EXT_DIV - 1) ? 0 : div_q + 1;
  end
  // Oscillation only after start-up, dropped on the next clock edge when disabled
  assign o_osc_present = (run_q >= START_CYC);
  assign o_ext_tick    = i_ext_valid && (div_q == 0);
endmodule

// ===== bench/standby_reset_control_bench.sv
`timescale 1ns/100ps
// Bench for the standby and reset sequencer
module standby_reset_control_bench;
  localparam int unsigned PRESC = 2;  // Short wait prescaler
  localparam int unsigned SBASE = 4;  // Short wait base
  localparam int unsigned EXDIV = 3;  // Cycles per external clock
  localparam int unsigned START = 40; // Crystal start-up cycles
  localparam logic [7:0]  CTRL  = standby_reset_pkg::OFS_CTRL;
  localparam logic [7:0]  ISTS  = standby_reset_pkg::OFS_ISTS;
  localparam logic [7:0]  CAUSE = standby_reset_pkg::OFS_CAUSE;
  localparam logic [7:0]  IMASK = standby_reset_pkg::OFS_IMASK;
  logic        i_clk_sys = 1'h0, i_reset = 1'h1, i_wr = 1'h0, i_rd = 1'h0;
  logic        i_stop_req = 1'h0, i_cpu_clk_ihs = 1'h0, i_reset_pin_n = 1'h1;
  logic        i_wdt_overflow = 1'h0, i_lvd_detect = 1'h0, i_poc_detect = 1'h0;
  logic        i_reset_low_port_pin_i = 1'h1, rd_d1 = 1'h0;
  logic [7:0]  i_addr = 8'h00, i_wdata = 8'h00, i_int_flag = 8'h00;
  logic [7:0]  i_int_mask = 8'hff, o_rdata;
  logic        i_main_osc_present, i_ext_clk_tick, o_reset_low_port_pin_o;
  logic        o_reset_low_port_pin_oe_n, o_port_hiz, o_cpu_clk_en, o_halt;
  logic        o_stop, o_main_crystal_osc_en, o_sub_crystal_osc_en, o_ihs_osc_en;
  logic        o_ils_osc_en, o_ext_main_clk_valid, o_ext_sub_clk_valid;
  logic        o_rst_core, o_rst_wdt, o_rst_lvd, o_irq;
  logic [15:0] ent;       // Oldest expected read: value, mask
  logic [15:0] exp_q[$];  // Expected reads in issue order
  int          n_fail = 0, checks_done = 0, cyc = 0, seed = 1, n;

  // System clock
  initial begin
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end

  standby_reset_control #(.PRESC(PRESC), .STAB_BASE(SBASE)) i_dut (.*);
  standby_far_side #(.START_CYC(START), .EXT_DIV(EXDIV)) i_far (
    .i_clk_sys(i_clk_sys), .i_osc_en(o_main_crystal_osc_en),
    .i_ext_valid(o_ext_main_clk_valid), .o_osc_present(i_main_osc_present),
    .o_ext_tick(i_ext_clk_tick));

  // Verdict and end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Compare read data
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t read %h expected %h", $time, got, exp);
    end
  endtask

  // Compare one output flag
  task automatic chk1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // Register write, strobe held into the next task
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'h1;
    i_rd <= 1'h0;
    i_addr <= a;
    i_wdata <= d;
  endtask

  // Register read, expectation noted for the watcher
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge i_clk_sys);
    exp_q.push_back({e & m, m});
    i_rd <= 1'h1;
    i_wr <= 1'h0;
    i_addr <= a;
  endtask

  // Release strobes, wait, then settle on a falling edge
  task automatic idle(input int k);
    @(posedge i_clk_sys);
    i_wr <= 1'h0;
    i_rd <= 1'h0;
    i_stop_req <= 1'h0;
    repeat (k) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
  endtask

  // Standby instruction
  task automatic pulse_stop;
    @(posedge i_clk_sys);
    i_stop_req <= 1'h1;
    idle(0);
  endtask

  // Request flags and masks
  task automatic set_irq(input logic [7:0] f, input logic [7:0] m);
    @(posedge i_clk_sys);
    i_int_flag <= f;
    i_int_mask <= m;
  endtask

  // One-cycle reset source pulse, s = poc, wdt, lvd
  task automatic src(input logic [2:0] s);
    @(posedge i_clk_sys);
    {i_poc_detect, i_wdt_overflow, i_lvd_detect} <= s;
    @(posedge i_clk_sys);
    {i_poc_detect, i_wdt_overflow, i_lvd_detect} <= 3'h0;
    @(negedge i_clk_sys);
  endtask

  // Count falling edges until the CPU clock returns
  task automatic wait_en(output int c);
    c = 0;
    while (o_cpu_clk_en !== 1'h1 && c < 5000) begin
      @(negedge i_clk_sys);
      c++;
    end
  endtask

  // Read watcher: oldest note against the data one cycle later
  always @(posedge i_clk_sys) begin
    rd_d1 <= i_rd;
    if (rd_d1 === 1'h1) begin
      ent = exp_q.pop_front();
      cmp8(o_rdata & ent[7:0], ent[15:8]);
    end
  end

  // Hang guard
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      n_fail++;
      stop_test();
    end
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge i_clk_sys);
    i_reset <= 1'h0;
    rd(CTRL, 8'h00, 8'hff);
    rd(CAUSE, 8'h00, 8'hff);
    rd(IMASK, 8'h00, 8'hff);
    rd(8'h20, 8'h00, 8'hff);
    wr(IMASK, 8'h0f);
    wr(CTRL, 8'h00);
    idle(1);
    $display("test reset values done");
    // Crystal must run first, else the halt wait stalls
    while (i_main_osc_present !== 1'h1) @(negedge i_clk_sys);
    // Pending unmasked source turns stop into halt
    set_irq(8'h01 << ($unsigned($random(seed)) % 8), 8'h00);
    pulse_stop();
    chk1(o_halt, 1'h1);
    wait_en(n);
    chk1(n <= SBASE * PRESC + 8, 1'h1);
    rd(ISTS, 8'h02, 8'h02);
    idle(1);
    chk1(o_irq, 1'h1);
    wr(IMASK, 8'h00);
    idle(1);
    chk1(o_irq, 1'h0);
    wr(IMASK, 8'h0f);
    wr(ISTS, 8'h0f);
    idle(1);
    chk1(o_irq, 1'h0);
    $display("test halt fallback done");
    // Crystal stop: wait counted only from oscillation
    set_irq(8'h01, 8'hff);
    pulse_stop();
    chk1(o_stop, 1'h1);
    chk1(o_ils_osc_en, 1'h1);
    set_irq(8'h01, 8'hfe);
    // Let the stopped crystal drop out first
    @(negedge i_clk_sys);
    while (i_main_osc_present !== 1'h1) @(negedge i_clk_sys);
    chk1(o_cpu_clk_en, 1'h0);
    wait_en(n);
    chk1(n >= SBASE * PRESC && n <= SBASE * PRESC + 5, 1'h1);
    $display("test crystal stop done");
    // Internal clock with amplifier option, low-speed oscillator off
    set_irq(8'h01, 8'hff);
    wr(CTRL, 8'h18);
    i_cpu_clk_ihs <= 1'h1;
    idle(1);
    pulse_stop();
    chk1(o_ils_osc_en, 1'h0);
    set_irq(8'h01, 8'hfe);
    wait_en(n);
    chk1(n >= standby_reset_pkg::HOLD_IHS_CYC, 1'h1);
    chk1(n <= standby_reset_pkg::HOLD_IHS_CYC + 6, 1'h1);
    // check wait status before crystal switch
    rd(standby_reset_pkg::OFS_STATE, 8'h08, 8'h0f);
    idle(0);
    set_irq(8'h01, 8'hff);
    i_cpu_clk_ihs <= 1'h0;
    wr(CTRL, 8'h08);
    idle(1);
    chk1(o_ils_osc_en, 1'h1);
    // External clock hold-off
    pulse_stop();
    set_irq(8'h01, 8'hfe);
    wait_en(n);
    chk1(n >= 160 * EXDIV, 1'h1);
    chk1(n <= START + SBASE * PRESC + 160 * EXDIV + 20, 1'h1);
    $display("test hold-off done");
    // Reset pin during stop, held low 10 us
    set_irq(8'h01, 8'hff);
    pulse_stop();
    @(posedge i_clk_sys);
    i_reset_pin_n <= 1'h0;
    repeat (1000) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    chk1(o_stop, 1'h1);
    chk1(o_reset_low_port_pin_oe_n, 1'h0);
    chk1(o_ils_osc_en | o_main_crystal_osc_en, 1'h0);
    repeat (1000) @(posedge i_clk_sys);
    i_reset_pin_n <= 1'h1;
    idle(1);
    chk1(o_cpu_clk_en, 1'h1);
    $display("test reset pin done");
    // Internal reset sources and cause flags
    src(3'h1);
    chk1(o_rst_core, 1'h1);
    chk1(o_rst_lvd, 1'h0);
    rd(CAUSE, 8'h01, 8'hff);
    rd(CAUSE, 8'h00, 8'hff);
    idle(0);
    src(3'h2);
    chk1(o_rst_wdt, 1'h1);
    rd(ISTS, 8'h08, 8'h08);
    rd(CAUSE, 8'h02, 8'hff);
    idle(0);
    src(3'h2);
    src(3'h4);
    rd(CAUSE, 8'h00, 8'hff);
    idle(2);
    $display("test reset sources done");
    stop_test();
  end
endmodule
